// >>> core/sfo_flash_timing.v
// How it works
// RL1: Capture input bits on rising clock, shift output bits on falling clock.
// RL2: Host samples each output bit on the following falling clock edge.
// RL3: Host launches each bit on rising edge; device captures next rising edge.
// RL4: Host keeps clock at most 50/85 MHz for read opcode 0x0B.
// RL5: Host keeps clock at most 40/50 MHz for read opcode 0x03.
// RL6: Host keeps clock at most 15 MHz for low-power read 01h.
// RL7: Host may run clock up to 66/104 MHz for read 0x1B.
// RL8: Protection follows write-protect pin within 1 us either way.
// RL9: Lockdown freeze completes within 200 us of select going high.
// RL10: Ultra-deep power-down entered within 3 us of select going high.
// RL11: Select low 20 ns wakes ultra-deep power-down; ready within 100 us.
// RL12: Deep power-down within 2 us; resume within 35 us of command.
// RL13: Page to buffer transfer or compare completes within 180 us.
// RL14: Page erase and program completes within 35 ms.
// RL15: Security register programming completes within 500 us.
// RL16: Host waits for busy to clear before dependent commands.
`timescale 1ns/1ps
`include "sfo_map.vh"

// ************************************************************
// Receive FIFO
// ************************************************************
module sfo_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `SFO_FIFO_DEPTH,
  parameter AW    = `SFO_FIFO_AW
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             inValid,
  output reg              inReady,
  input  wire [WIDTH-1:0] inData,
  output reg              outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr;
  reg [AW-1:0]    rdPtr;
  reg [AW:0]      count;
  wire            doPush = inValid & inReady;
  wire            doPop  = outValid & outReady;
  reg [AW:0]      next_count;

  assign outData = mem[rdPtr];

  // Occupancy after this cycle's push and pop
  always @*
  begin
    next_count = count;
    if (doPush & ~doPop)
      next_count = count + 1'b1;
    else if (doPop & ~doPush)
      next_count = count - 1'b1;
  end

  // Flags are registered from the next count so they are never stale
  always @(posedge clk)
  begin
    if (rst)
    begin
      wrPtr    <= {AW{1'b0}};
      rdPtr    <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      inReady  <= 1'b1;
      outValid <= 1'b0;
    end
    else
    begin
      if (doPush)
      begin
        mem[wrPtr] <= inData;
        wrPtr      <= wrPtr + 1'b1;
      end
      if (doPop)
        rdPtr <= rdPtr + 1'b1;
      count    <= next_count;
      inReady  <= (next_count != DEPTH[AW:0]);
      outValid <= (next_count != {(AW+1){1'b0}});
    end
  end
endmodule // sfo_fifo

// ************************************************************
// Flash operation sequencer
// ************************************************************
module sfo_flash_timing #(
  parameter [`SFO_TMR_W-1:0] LOCK_CYC  = `SFO_LOCK_CYC,
  parameter [`SFO_TMR_W-1:0] XUDPD_CYC = `SFO_XUDPD_CYC,
  parameter [`SFO_TMR_W-1:0] RDPD_CYC  = `SFO_RDPD_CYC,
  parameter [`SFO_TMR_W-1:0] XFR_CYC   = `SFO_XFR_CYC,
  parameter [`SFO_TMR_W-1:0] EP_CYC    = `SFO_EP_CYC,
  parameter [`SFO_TMR_W-1:0] OTPP_CYC  = `SFO_OTPP_CYC
) (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       sck,
  input  wire       csN,
  input  wire       mosi,
  input  wire       wpN,
  output reg        miso,
  output reg        misoOeN,
  output reg        rdReq,
  input  wire [7:0] rdData,
  output wire       rxValid,
  input  wire       rxReady,
  output wire [7:0] rxData,
  output reg        rxOverrun,
  output reg        busy,
  output reg        deepPd,
  output reg        ultraDeepPd,
  output reg        protectOn,
  output reg        lockFrozen,
  output reg        opDone
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_BUSY = 5'h02;
  localparam [4:0] ST_DPD  = 5'h04;
  localparam [4:0] ST_UDPD = 5'h08;
  localparam [4:0] ST_WAKE = 5'h10;
  localparam [`SFO_TMR_W-1:0] WP_CYC    = `SFO_WP_CYC - 3;
  localparam [`SFO_TMR_W-1:0] EUDPD_CYC = `SFO_EUDPD_CYC;
  localparam [`SFO_TMR_W-1:0] EDPD_CYC  = `SFO_EDPD_CYC;
  localparam [`SFO_TMR_W-1:0] CSLU_CYC  = `SFO_CSLU_CYC;

  reg [2:0]            sckS;
  reg [2:0]            csS;
  reg [1:0]            mosiS;
  reg [1:0]            wpS;
  reg [4:0]            state;
  reg [7:0]            shIn;
  reg [7:0]            shOut;
  reg [2:0]            bitCnt;
  reg [2:0]            outCnt;
  reg                  haveOp;
  reg                  reading;
  reg [7:0]            opcode;
  reg [7:0]            curOp;
  reg [`SFO_TMR_W-1:0] opTimer;
  reg [`SFO_TMR_W-1:0] wpTimer;
  reg [`SFO_TMR_W-1:0] csLowCnt;
  reg                  rxPush;
  wire                 rxInReady;
  wire                 sel    = ~csS[1];
  wire                 sckUp  = sckS[1] & ~sckS[2] & sel;
  wire                 sckDn  = ~sckS[1] & sckS[2] & sel;
  wire                 csRise = csS[1] & ~csS[2];
  wire [7:0]           inByte = {shIn[6:0], mosiS[1]};

  // Continuous read opcodes, checked only when the opcode byte is captured
  function isRead;
    input [7:0] op;
    begin
      isRead = (op == `SFO_OP_RD_FAST) | (op == `SFO_OP_RD_SLOW) |
               (op == `SFO_OP_RD_LOWPWR) | (op == `SFO_OP_RD_TURBO); // RL4 RL5 RL6 RL7
    end
  endfunction

  // Duration of each timed operation; zero means not timed
  function [`SFO_TMR_W-1:0] opTime;
    input [7:0] op;
    begin
      case (op)
        `SFO_OP_LOCK: opTime = LOCK_CYC;   // RL9
        `SFO_OP_UDPD: opTime = EUDPD_CYC;  // RL10
        `SFO_OP_DPD:  opTime = EDPD_CYC;   // RL12
        `SFO_OP_XFR:  opTime = XFR_CYC;    // RL13
        `SFO_OP_COMP: opTime = XFR_CYC;    // RL13
        `SFO_OP_EP:   opTime = EP_CYC;     // RL14
        `SFO_OP_OTPP: opTime = OTPP_CYC;   // RL15
        default:      opTime = {`SFO_TMR_W{1'b0}};
      endcase
    end
  endfunction

  // ************************************************************
  // Pin synchronisers; edges are taken from the second stage on
  // ************************************************************
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      sckS  <= 3'h0;
      csS   <= 3'h7;
      mosiS <= 2'h0;
      wpS   <= 2'h3;
    end
    else
    begin
      sckS  <= {sckS[1:0], sck};
      csS   <= {csS[1:0], csN};
      mosiS <= {mosiS[0], mosi};
      wpS   <= {wpS[0], wpN};
    end
  end

  // ************************************************************
  // Serial shifter
  // ************************************************************
  always @(posedge ref_clk)
  begin
    if (rst | ~sel)
    begin
      shIn    <= 8'h00;
      bitCnt  <= 3'h0;
      outCnt  <= 3'h0;
      haveOp  <= 1'b0;
      reading <= 1'b0;
      rxPush  <= 1'b0;
      rdReq   <= 1'b0;
      shOut   <= 8'h00;
      miso    <= 1'b0;
      misoOeN <= 1'b1;
      if (rst)
        opcode <= 8'h00;
    end
    else
    begin
      rxPush <= 1'b0;
      rdReq  <= 1'b0;
      // Capture on the rising edge only
      if (sckUp)
      begin
        shIn   <= inByte;                      // RL1 RL3
        bitCnt <= bitCnt + 1'b1;
        if (bitCnt == 3'h7)
        begin
          if (~haveOp)
          begin
            opcode  <= inByte;
            haveOp  <= 1'b1;
            reading <= isRead(inByte) & state[0];
          end
          else if (~reading)
            rxPush <= 1'b1;
        end
      end
      // Launch on the falling edge, giving the host a full cycle
      if (sckDn & reading)
      begin
        misoOeN <= 1'b0;
        outCnt  <= outCnt + 1'b1;
        if (outCnt == 3'h0)
        begin
          miso  <= rdData[7];                  // RL1 RL2
          shOut <= {rdData[6:0], 1'b0};
          rdReq <= 1'b1;
        end
        else
        begin
          miso  <= shOut[7];                   // RL1 RL2
          shOut <= {shOut[6:0], 1'b0};
        end
      end
    end
  end

  // Overflow is sticky: a byte lost to a full FIFO cannot be recovered
  always @(posedge ref_clk)
  begin
    if (rst)
      rxOverrun <= 1'b0;
    else if (rxPush & ~rxInReady)
      rxOverrun <= 1'b1;
  end

  sfo_fifo #(
    .WIDTH (8),
    .DEPTH (`SFO_FIFO_DEPTH),
    .AW    (`SFO_FIFO_AW)
  ) rxFifo (
    .clk      (ref_clk),
    .rst      (rst),
    .inValid  (rxPush),
    .inReady  (rxInReady),
    .inData   (shIn),
    .outValid (rxValid),
    .outReady (rxReady),
    .outData  (rxData)
  );

  // ************************************************************
  // Write-protect follower with settle counter
  // ************************************************************
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      protectOn <= 1'b0;
      wpTimer   <= {`SFO_TMR_W{1'b0}};
    end
    else if (protectOn == ~wpS[1])
      wpTimer <= {`SFO_TMR_W{1'b0}};
    else if (wpTimer >= WP_CYC)
    begin
      protectOn <= ~wpS[1];                    // RL8
      wpTimer   <= {`SFO_TMR_W{1'b0}};
    end
    else
      wpTimer <= wpTimer + 1'b1;
  end

  // ************************************************************
  // Operation state machine
  // ************************************************************
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state       <= ST_IDLE;
      curOp       <= 8'h00;
      opTimer     <= {`SFO_TMR_W{1'b0}};
      csLowCnt    <= {`SFO_TMR_W{1'b0}};
      busy        <= 1'b0;
      deepPd      <= 1'b0;
      ultraDeepPd <= 1'b0;
      lockFrozen  <= 1'b0;
      opDone      <= 1'b0;
    end
    else
    begin
      opDone <= 1'b0;
      if (opTimer != {`SFO_TMR_W{1'b0}})
        opTimer <= opTimer - 1'b1;
      case (state)
        ST_IDLE:
          // Commands take effect when select is released
          if (csRise & haveOp & (opTime(opcode) != {`SFO_TMR_W{1'b0}}))
          begin
            state   <= ST_BUSY;
            curOp   <= opcode;
            opTimer <= opTime(opcode) - 1'b1;
            busy    <= 1'b1;                   // RL16
          end
        ST_BUSY:
          if (opTimer == {`SFO_TMR_W{1'b0}})
          begin
            opDone <= 1'b1;
            busy   <= 1'b0;
            state  <= ST_IDLE;
            if (curOp == `SFO_OP_LOCK)
              lockFrozen <= 1'b1;              // RL9
            if (curOp == `SFO_OP_UDPD)
            begin
              ultraDeepPd <= 1'b1;             // RL10
              csLowCnt    <= {`SFO_TMR_W{1'b0}};
              state       <= ST_UDPD;
            end
            if (curOp == `SFO_OP_DPD)
            begin
              deepPd <= 1'b1;                  // RL12
              state  <= ST_DPD;
            end
          end
        ST_DPD:
          // Only the resume command is heard here
          if (csRise & haveOp & (opcode == `SFO_OP_RESUME))
          begin
            opTimer <= RDPD_CYC - 1'b1;        // RL12
            busy    <= 1'b1;
            state   <= ST_WAKE;
          end
        ST_UDPD:
          // Any select pulse long enough wakes the part
          if (~sel)
            csLowCnt <= {`SFO_TMR_W{1'b0}};
          else if (csLowCnt >= CSLU_CYC - 1'b1)
          begin
            opTimer <= XUDPD_CYC - 1'b1;       // RL11
            busy    <= 1'b1;
            state   <= ST_WAKE;
          end
          else
            csLowCnt <= csLowCnt + 1'b1;      // RL11
        ST_WAKE:
          if (opTimer == {`SFO_TMR_W{1'b0}})
          begin
            deepPd      <= 1'b0;
            ultraDeepPd <= 1'b0;
            busy        <= 1'b0;
            opDone      <= 1'b1;
            state       <= ST_IDLE;            // RL11 RL12
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule // sfo_flash_timing

// >>> core/sfo_map.vh
`ifndef SFO_MAP_VH
`define SFO_MAP_VH

// ************************************************************
// Clock
// ************************************************************
`define SFO_CLK_NS        5

// ************************************************************
// Operation times, in their own units
// ************************************************************
`define SFO_T_WP_US       1
`define SFO_T_LOCK_US     200
`define SFO_T_EUDPD_US    3
`define SFO_T_CSLU_NS     20
`define SFO_T_XUDPD_US    100
`define SFO_T_EDPD_US     2
`define SFO_T_RDPD_US     35
`define SFO_T_XFR_US      180
`define SFO_T_EP_MS       35
`define SFO_T_OTPP_US     500

// ************************************************************
// Cycle counts: longest times round down, least times round up
// ************************************************************
`define SFO_WP_CYC     ((`SFO_T_WP_US * 1000) / `SFO_CLK_NS)
`define SFO_LOCK_CYC   ((`SFO_T_LOCK_US * 1000) / `SFO_CLK_NS)
`define SFO_EUDPD_CYC  ((`SFO_T_EUDPD_US * 1000) / `SFO_CLK_NS)
`define SFO_CSLU_CYC   ((`SFO_T_CSLU_NS + `SFO_CLK_NS - 1) / `SFO_CLK_NS)
`define SFO_XUDPD_CYC  ((`SFO_T_XUDPD_US * 1000) / `SFO_CLK_NS)
`define SFO_EDPD_CYC   ((`SFO_T_EDPD_US * 1000) / `SFO_CLK_NS)
`define SFO_RDPD_CYC   ((`SFO_T_RDPD_US * 1000) / `SFO_CLK_NS)
`define SFO_XFR_CYC    ((`SFO_T_XFR_US * 1000) / `SFO_CLK_NS)
`define SFO_EP_CYC     ((`SFO_T_EP_MS * 1000000) / `SFO_CLK_NS)
`define SFO_OTPP_CYC   ((`SFO_T_OTPP_US * 1000) / `SFO_CLK_NS)

// ************************************************************
// Opcodes
// ************************************************************
`define SFO_OP_RD_FAST    8'h0b
`define SFO_OP_RD_SLOW    8'h03
`define SFO_OP_RD_LOWPWR  8'h01
`define SFO_OP_RD_TURBO   8'h1b
`define SFO_OP_LOCK       8'h7f
`define SFO_OP_UDPD       8'h79
`define SFO_OP_DPD        8'hb9
`define SFO_OP_RESUME     8'hab
`define SFO_OP_XFR        8'h53
`define SFO_OP_COMP       8'h60
`define SFO_OP_EP         8'h83
`define SFO_OP_OTPP       8'h9b

// ************************************************************
// Sizes
// ************************************************************
`define SFO_FIFO_DEPTH    8
`define SFO_FIFO_AW       3
`define SFO_TMR_W         24

`endif

// >>> tb/sfo_chk_assertions.sv
`timescale 1ns/1ps
`include "sfo_map.vh"
// ************************************************************
// Link and operation timing checker
// ************************************************************
module sfo_chk #(
  parameter LOCK_CYC  = 50,
  parameter XUDPD_CYC = 60,
  parameter RDPD_CYC  = 70,
  parameter EP_CYC    = 90
) (
  input wire ref_clk,
  input wire rst,
  input wire sck,
  input wire csN,
  input wire wpN,
  input wire miso,
  input wire misoOeN,
  input wire busy,
  input wire deepPd,
  input wire ultraDeepPd,
  input wire protectOn,
  input wire lockFrozen
);
  reg [23:0] csCnt;
  reg        csPrev;

  // Cycles since select rose; saturates so a stale frame never wraps
  always @(posedge ref_clk)
  begin
    csPrev <= csN;
    if (rst || (csN && !csPrev))
      csCnt <= 24'h0;
    else if (csCnt != 24'hffffff)
      csCnt <= csCnt + 24'h1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_miso_hold: assert property (sck [*4] |-> $stable(miso))
    else $error("data out moved while clock high");
  a_oe_off: assert property (csN [*6] |-> misoOeN)
    else $error("data out driven while deselected");
  a_wp_on: assert property ($fell(wpN) |-> ##[1:200] protectOn)
    else $error("protection late after pin low");
  a_wp_off: assert property ($rose(wpN) |-> ##[1:200] !protectOn)
    else $error("protection late after pin high");
  a_lock_time: assert property ($rose(lockFrozen) |-> csCnt <= LOCK_CYC + 8)
    else $error("lockdown freeze late");
  a_udpd_entry: assert property ($rose(ultraDeepPd) |-> csCnt <= `SFO_EUDPD_CYC + 8)
    else $error("ultra deep entry late");
  a_udpd_exit: assert property ($fell(ultraDeepPd) |-> csCnt <= XUDPD_CYC + 8)
    else $error("ultra deep exit late");
  a_dpd_entry: assert property ($rose(deepPd) |-> csCnt <= `SFO_EDPD_CYC + 8)
    else $error("deep entry late");
  a_dpd_resume: assert property ($fell(deepPd) |-> csCnt <= RDPD_CYC + 8)
    else $error("deep resume late");
  a_busy_start: assert property ($rose(busy) && !ultraDeepPd |-> csCnt <= 8)
    else $error("busy not tied to select rise");
  a_busy_bound: assert property (busy |-> csCnt <= EP_CYC + 8)
    else $error("operation overran its limit");
endmodule // sfo_chk

bind sfo_flash_timing sfo_chk #(.LOCK_CYC(LOCK_CYC), .XUDPD_CYC(XUDPD_CYC),
  .RDPD_CYC(RDPD_CYC), .EP_CYC(EP_CYC)) chk (.ref_clk, .rst, .sck, .csN, .wpN,
  .miso, .misoOeN, .busy, .deepPd, .ultraDeepPd, .protectOn, .lockFrozen);

// >>> tb/sfo_host_model.sv
`timescale 1ns/1ps
// ************************************************************
// Host side of the serial link
// ************************************************************
module sfo_host_model (
  output reg  sck,
  output reg  csN,
  output reg  mosi,
  input  wire miso
);
  localparam real HALF = 62.5; // 8 MHz, under every read limit

  // Idle link: clock parked low, device deselected
  initial
  begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end

  // One frame of opcode plus nb bytes; r keeps the last eight bits seen
  task automatic xfer(input [79:0] v, input int nb, output [7:0] r);
    int i;
    begin
      // Deselect gap first, so back-to-back frames still show a select rise
      #(2 * HALF + 1.3) csN = 1'b0;
      mosi = v[79];
      #HALF;
      for (i = 1; i <= 8 * nb + 8; i++)
      begin
        sck = 1'b1;
        #10 mosi = (i < 80) ? v[79 - i] : ~mosi;
        #(HALF - 10) sck = 1'b0;
        r = {r[6:0], miso};
        #HALF;
      end
      csN = 1'b1;
      mosi = ~mosi;
    end
  endtask

  // Select pulse of 40 ns, twice the wake floor, to leave deepest sleep
  task automatic wake();
    begin
      #1.3 csN = 1'b0;
      #40 csN = 1'b1;
    end
  endtask
endmodule // sfo_host_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "sfo_map.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ************************************************************
// Bench top
// ************************************************************
module tb_top;
  localparam LOCK = 50, XUDPD = 60, RDPD = 70, XFR = 80, EP = 700, OTPP = 100;
  reg        ref_clk = 1'b0;
  reg        rst     = 1'b1;
  reg        wpN     = 1'b1;
  reg        rxReady = 1'b0;
  reg  [7:0] rdData  = 8'h00;
  reg  [7:0] r;
  wire       sck, csN, mosi, miso, misoOeN, rxValid, rxOverrun;
  wire       busy, deepPd, ultraDeepPd, protectOn, lockFrozen, opDone, rdReq;
  wire [7:0] rxData;
  wire [3:0] flags    = {ultraDeepPd, deepPd, protectOn, opDone};
  wire       misoLine = misoOeN ? ref_clk : miso; // Released line toggles
  int        error_cnt = 0;
  int        n_tests   = 0;
  int        n;
  int        nReq      = 0;

  always #2.5 ref_clk = ~ref_clk;

  // Byte requests seen; the pre-edge value is read, so each pulse counts once
  always @(posedge ref_clk)
  begin
    if (rdReq)
      nReq++;
  end

  sfo_host_model host (.sck(sck), .csN(csN), .mosi(mosi), .miso(misoLine));

  // Long counts shrunk so the run stays short
  sfo_flash_timing #(.LOCK_CYC(LOCK), .XUDPD_CYC(XUDPD), .RDPD_CYC(RDPD),
    .XFR_CYC(XFR), .EP_CYC(EP), .OTPP_CYC(OTPP)) dut (.ref_clk(ref_clk),
    .rst(rst), .sck(sck), .csN(csN), .mosi(mosi), .wpN(wpN), .miso(miso),
    .misoOeN(misoOeN), .rdReq(rdReq), .rdData(rdData), .rxValid(rxValid),
    .rxReady(rxReady), .rxData(rxData), .rxOverrun(rxOverrun), .busy(busy),
    .deepPd(deepPd), .ultraDeepPd(ultraDeepPd), .protectOn(protectOn),
    .lockFrozen(lockFrozen), .opDone(opDone));

  task automatic print_verdict();
    begin
      $display("errors %0d of %0d checks", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // Bounded wait for one status flag; a spent bound ends the run
  task automatic waitSig(input int s, input v, input int lim);
    begin
      n = 0;
      #1;
      while (flags[s] !== v && n <= lim)
      begin
        // Look after the edge, once the flags have settled
        @(posedge ref_clk);
        #1;
        n++;
      end
      `CHK(n <= lim, 1'b1)
      if (n > lim)
        print_verdict();
    end
  endtask

  task automatic t_reads();
    logic [7:0] ops [4] = '{8'h0b, 8'h03, 8'h01, 8'h1b};
    int i;
    int m;
    begin
      for (i = 0; i < 4; i++)
      begin
        @(posedge ref_clk) rdData <= ops[i] ^ 8'h5a;
        m = nReq;
        host.xfer({ops[i], 72'h0}, 1, r);
        `CHK(r, ops[i] ^ 8'h5a)
        `CHK(nReq - m, 2)
        repeat (8) @(posedge ref_clk);
        `CHK(misoOeN, 1'b1)
      end
    end
  endtask

  // Nine bytes into an eight deep buffer while the reader stalls
  task automatic t_fifo();
    int i;
    begin
      host.xfer({8'h53, 72'h112233445566778899}, 9, r);
      `CHK(rxOverrun, 1'b1)
      waitSig(0, 1'b1, XFR + 8);
      `CHK(n >= XFR, 1'b1)
      for (i = 0; i < 8; i++)
      begin
        #1;
        `CHK(rxData, 8'(8'h11 * (i + 1)))
        @(posedge ref_clk) rxReady <= 1'b1;
        @(posedge ref_clk) rxReady <= 1'b0;
      end
      @(posedge ref_clk);
      #1;
      `CHK(rxValid, 1'b0)
    end
  endtask

  task automatic t_timed();
    logic [7:0] ops [4] = '{8'h7f, 8'h83, 8'h9b, 8'h60};
    int lims [4] = '{LOCK, EP, OTPP, XFR};
    int i;
    begin
      for (i = 0; i < 4; i++)
      begin
        host.xfer({ops[i], 72'h0}, 0, r);
        waitSig(0, 1'b1, lims[i] + 8);
        `CHK(n >= lims[i], 1'b1)
        `CHK(busy, 1'b0)
        repeat (4) @(posedge ref_clk);
      end
      `CHK(lockFrozen, 1'b1)
    end
  endtask

  // Deep sleep ignores a read; ultra deep wakes on a bare select pulse
  task automatic t_pd();
    begin
      host.xfer({8'hb9, 72'h0}, 0, r);
      waitSig(2, 1'b1, `SFO_EDPD_CYC + 8);
      host.xfer({8'h0b, 72'h0}, 1, r);
      `CHK(deepPd, 1'b1)
      host.xfer({8'hab, 72'h0}, 0, r);
      waitSig(2, 1'b0, RDPD + 8);
      `CHK(n >= RDPD, 1'b1)
      repeat (4) @(posedge ref_clk);
      host.xfer({8'h79, 72'h0}, 0, r);
      waitSig(3, 1'b1, `SFO_EUDPD_CYC + 8);
      host.wake();
      waitSig(3, 1'b0, XUDPD + 8);
      `CHK(n >= XUDPD - 8, 1'b1)
    end
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK(misoOeN, 1'b1)
    t_reads();
    t_fifo();
    t_timed();
    t_pd();
    @(posedge ref_clk) wpN <= 1'b0;
    waitSig(1, 1'b1, `SFO_WP_CYC);
    @(posedge ref_clk) wpN <= 1'b1;
    waitSig(1, 1'b0, `SFO_WP_CYC);
    print_verdict();
  end
endmodule // tb_top
